// ==== crf_core.sv ====
// Purpose: architectural register state of the cpu core: general registers,
//          program counter, extended control and condition code with flag logic
// Assumes: the execution datapath drives one request per port per cycle
// Notes: read data, store data and selected bit come back one cycle after request
`timescale 1ns/1ps

// Overview of operation
// - eight 32-bit general registers, used as address or data, 32/16/8-bit access.
// - each wide register splits into independent extended and base 16-bit halves.
// - the extended half is the upper 16 bits of the wide register.
// - each base half splits into independent high and low bytes.
// - general register seven doubles as the stack pointer for calls and exceptions.
// - 24-bit program counter; its lowest bit reads as zero on fetch.
// - extended control bit 7 enables trace exceptions after every instruction.
// - extended control bits 6 to 3 always read as one.
// - extended control bits 2 to 0 hold interrupt mask level 0 to 7.
// - load, and, or, xor control ops modify the extended control register; store only reads it.
// - load/and/or/xor to extended control block all interrupts three states; store doesn't.
// - condition bit 7 masks non-NMI interrupts; set at every exception start.
// - condition bits 6 and 4 are plain user bits; bit 6 never masks.
// - half-carry from bit 3, 11 or 27 on add, subtract, compare, negate.
// - negative flag takes the sign bit of the result at operation width.
// - zero flag set for zero result, cleared otherwise.
// - overflow flag set on arithmetic overflow, cleared otherwise.
// - carry records carry, borrow, shifted-out bit, or bit accumulator.
// - N, Z, V, C feed branches; non-flag instructions leave them unchanged.
// - reset clears trace, sets both masks; PC loaded from vector afterwards.
// - bit ops pick bit n of a byte; decimal adjust sees two BCD digits.
module crf_core (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic gr_wr_en,
   input wire logic [2:0] gr_wr_idx,
   input wire logic [1:0] gr_wr_size,
   input wire logic gr_wr_sel,
   input wire logic [31:0] gr_wr_data,
   input wire logic [2:0] gr_rd_idx,
   input wire logic [1:0] gr_rd_size,
   input wire logic gr_rd_sel,
   input wire logic [2:0] bit_sel,
   output logic [31:0] gr_rd_data,
   output logic rd_bit,
   output logic [3:0] bcd_upper,
   output logic [3:0] bcd_lower,
   output logic [31:0] stack_reg,
   input wire logic pc_load_en,
   input wire logic [23:0] pc_load_val,
   input wire logic pc_inc_en,
   output logic [23:0] program_counter,
   output logic [23:0] fetch_addr,
   input wire logic ctl_op_en,
   input wire logic [2:0] ctl_op,
   input wire logic ctl_to_ext,
   input wire logic [7:0] ctl_operand,
   output logic [7:0] ctl_store_data,
   input wire logic exc_start,
   input wire logic flag_en,
   input wire logic [2:0] flag_kind,
   input wire logic [1:0] flag_size,
   input wire logic flag_use_x,
   input wire logic [31:0] flag_a,
   input wire logic [31:0] flag_b,
   input wire logic flag_shift_out,
   input wire logic flag_bit_val,
   output logic [31:0] alu_result,
   output logic [7:0] extended_control,
   output logic [7:0] condition_code,
   output logic trace_en,
   output logic [2:0] mask_level,
   output logic irq_mask_i,
   output logic irq_block,
   output logic flag_n,
   output logic flag_z,
   output logic flag_v,
   output logic flag_c
);

   crf_pkg::crf_state_s q;
   crf_pkg::crf_state_s d;
   logic [31:0] msk;
   logic [31:0] hm;
   logic [4:0] sgn;
   logic [5:0] cbit;
   logic [5:0] hbit;
   logic [31:0] opa;
   logic [31:0] opb;
   logic cin;
   logic [32:0] sum;
   logic [32:0] hsum;
   logic [31:0] res;
   logic [7:0] ctl_cur;
   logic [7:0] ctl_new;
   logic [31:0] rd_byte;

   // mask of the live bits for an operand width
   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      case (sz)
         crf_pkg::SZ_BYTE: size_mask = 32'h000000FF;
         crf_pkg::SZ_WORD: size_mask = 32'h0000FFFF;
         default: size_mask = 32'hFFFFFFFF;
      endcase
   endfunction

   // merge a sub-register write into the old wide value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [1:0] sz,
                                         input logic sel, input logic [31:0] wd);
      merge = old;
      case (sz)
         crf_pkg::SZ_BYTE: begin
            if (sel) begin
               merge[15:8] = wd[7:0];
            end else begin
               merge[7:0] = wd[7:0];
            end
         end
         crf_pkg::SZ_WORD: begin
            if (sel) begin
               merge[31:16] = wd[15:0];
            end else begin
               merge[15:0] = wd[15:0];
            end
         end
         default: merge = wd;
      endcase
   endfunction

   // pull a sub-register out of a wide value, right aligned
   function automatic logic [31:0] extract(input logic [31:0] v, input logic [1:0] sz,
                                           input logic sel);
      case (sz)
         crf_pkg::SZ_BYTE: extract = {24'h000000, sel ? v[15:8] : v[7:0]};
         crf_pkg::SZ_WORD: extract = {16'h0000, sel ? v[31:16] : v[15:0]};
         default: extract = v;
      endcase
   endfunction

   // apply a control-register instruction to a byte
   function automatic logic [7:0] ctl_apply(input logic [2:0] op, input logic [7:0] cur,
                                            input logic [7:0] opd);
      case (op)
         crf_pkg::CO_LOAD: ctl_apply = opd;
         crf_pkg::CO_AND: ctl_apply = cur & opd;
         crf_pkg::CO_OR: ctl_apply = cur | opd;
         crf_pkg::CO_XOR: ctl_apply = cur ^ opd;
         default: ctl_apply = cur;
      endcase
   endfunction

   // arithmetic core of the flag unit; width picks sign, carry and half-carry bits
   always_comb begin
      msk = size_mask(flag_size);
      case (flag_size)
         crf_pkg::SZ_BYTE: begin
            sgn = 5'h07;
            cbit = 6'h08;
            hbit = 6'h04;
         end
         crf_pkg::SZ_WORD: begin
            sgn = 5'h0F;
            cbit = 6'h10;
            hbit = 6'h0C;
         end
         default: begin
            sgn = 5'h1F;
            cbit = 6'h20;
            hbit = 6'h1C;
         end
      endcase
      hm = (32'h00000001 << hbit) - 32'h00000001;
      cin = flag_use_x & q.cond[crf_pkg::CC_C];
      opa = flag_a & msk;
      opb = flag_b & msk;
      if (flag_kind == crf_pkg::FK_NEG) begin
         opa = 32'h00000000;
         opb = flag_a & msk;
      end
      if (flag_kind == crf_pkg::FK_ADD) begin
         sum = {1'b0, opa} + {1'b0, opb} + {32'h00000000, cin};
         hsum = {1'b0, opa & hm} + {1'b0, opb & hm} + {32'h00000000, cin};
      end else begin
         // a negative difference sets every bit above, so the borrow shows at any index
         sum = {1'b0, opa} - {1'b0, opb} - {32'h00000000, cin};
         hsum = {1'b0, opa & hm} - {1'b0, opb & hm} - {32'h00000000, cin};
      end
      if (flag_kind == crf_pkg::FK_ADD || flag_kind == crf_pkg::FK_SUB ||
          flag_kind == crf_pkg::FK_NEG) begin
         res = sum[31:0] & msk;
      end else begin
         res = flag_a & msk;
      end
   end

   // next-state logic for the whole register file
   always_comb begin
      d = q;
      ctl_cur = ctl_to_ext ? {q.trace, crf_pkg::XC_RSVD, q.mask} : q.cond;
      ctl_new = ctl_apply(ctl_op, ctl_cur, ctl_operand);
      // registered read port, byte and bit views included
      d.rd = extract(q.gr[gr_rd_idx], gr_rd_size, gr_rd_sel);
      rd_byte = extract(q.gr[gr_rd_idx], crf_pkg::SZ_BYTE, gr_rd_sel);
      d.rd_bit = rd_byte[bit_sel];
      if (gr_wr_en) begin
         d.gr[gr_wr_idx] = merge(q.gr[gr_wr_idx], gr_wr_size, gr_wr_sel, gr_wr_data);
      end
      // a load wins over a step so vector fetch and jumps take effect
      if (pc_load_en) begin
         d.pc = pc_load_val;
      end else if (pc_inc_en) begin
         d.pc = q.pc + crf_pkg::PC_STEP;
      end
      // interrupt hold-off counts down one state per cycle
      if (q.blk != 2'h0) begin
         d.blk = q.blk - 2'h1;
      end
      // flag unit; untouched flags keep their value
      if (flag_en) begin
         // result kept so the datapath can write it back
         d.alu = res;
         case (flag_kind)
            crf_pkg::FK_ADD, crf_pkg::FK_SUB, crf_pkg::FK_NEG: begin
               d.cond[crf_pkg::CC_H] = hsum[hbit];
               d.cond[crf_pkg::CC_N] = res[sgn];
               d.cond[crf_pkg::CC_Z] = (res == 32'h00000000);
               if (flag_kind == crf_pkg::FK_ADD) begin
                  d.cond[crf_pkg::CC_V] = (opa[sgn] == opb[sgn]) && (res[sgn] != opa[sgn]);
               end else begin
                  d.cond[crf_pkg::CC_V] = (opa[sgn] != opb[sgn]) && (res[sgn] != opa[sgn]);
               end
               d.cond[crf_pkg::CC_C] = sum[cbit];
            end
            crf_pkg::FK_LOGIC, crf_pkg::FK_SHIFT: begin
               d.cond[crf_pkg::CC_N] = res[sgn];
               d.cond[crf_pkg::CC_Z] = (res == 32'h00000000);
               d.cond[crf_pkg::CC_V] = 1'b0;
               if (flag_kind == crf_pkg::FK_SHIFT) begin
                  d.cond[crf_pkg::CC_C] = flag_shift_out;
               end
            end
            crf_pkg::FK_BIT: d.cond[crf_pkg::CC_C] = flag_bit_val;
            default: d.cond = q.cond;
         endcase
      end
      // control instructions take priority over a same-cycle flag update
      if (ctl_op_en) begin
         if (ctl_op == crf_pkg::CO_STORE) begin
            d.store_control_op = ctl_cur;
         end else if (ctl_to_ext) begin
            d.trace = ctl_new[crf_pkg::XC_TRACE];
            d.mask = ctl_new[2:0];
            d.blk = crf_pkg::BLK_STATES;
         end else begin
            d.cond = ctl_new;
         end
      end
      // exception entry always leaves the mask set, whatever else wrote it
      if (exc_start) begin
         d.cond[crf_pkg::CC_I] = 1'b1;
      end
   end

   // one register for all state; general registers get zero only for determinism
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= crf_pkg::STATE_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign gr_rd_data = q.rd;
   assign rd_bit = q.rd_bit;
   assign bcd_upper = q.rd[7:4];
   assign bcd_lower = q.rd[3:0];
   assign stack_reg = q.gr[crf_pkg::SP_IDX];
   assign program_counter = q.pc;
   assign fetch_addr = {q.pc[23:1], 1'b0};
   assign ctl_store_data = q.store_control_op;
   assign alu_result = q.alu;
   assign extended_control = {q.trace, crf_pkg::XC_RSVD, q.mask};
   assign condition_code = q.cond;
   assign trace_en = q.trace;
   assign mask_level = q.mask;
   assign irq_mask_i = q.cond[crf_pkg::CC_I];
   assign irq_block = (q.blk != 2'h0);
   assign flag_n = q.cond[crf_pkg::CC_N];
   assign flag_z = q.cond[crf_pkg::CC_Z];
   assign flag_v = q.cond[crf_pkg::CC_V];
   assign flag_c = q.cond[crf_pkg::CC_C];

   // checks
   ext_store_ones_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl_op_en && ctl_op == crf_pkg::CO_STORE && ctl_to_ext) |=>
      ctl_store_data[6:3] == 4'hF && extended_control[6:3] == 4'hF)
      else $error("reserved control bits not one");

   ext_hold_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl_op_en && ctl_to_ext && ctl_op != crf_pkg::CO_STORE) |=> irq_block [*3])
      else $error("interrupt hold-off shorter than three states");

   hold_off_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl_op_en && ctl_to_ext && ctl_op != crf_pkg::CO_STORE) ##1
      !ctl_op_en [*3] |=> !irq_block) else $error("interrupt hold-off too long");

   store_no_block_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl_op_en && ctl_op == crf_pkg::CO_STORE && !irq_block) |=> !irq_block)
      else $error("store control op blocked interrupts");

   exc_sets_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      exc_start |=> irq_mask_i) else $error("exception start left mask clear");

   fetch_even_a: assert property (@(posedge ref_clk) disable iff (rst)
      fetch_addr[0] == 1'b0 && fetch_addr[23:1] == program_counter[23:1])
      else $error("fetch address not even");

   sp_byte_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (gr_wr_en && gr_wr_idx == crf_pkg::SP_IDX && gr_wr_size == crf_pkg::SZ_BYTE &&
       !gr_wr_sel) |=> stack_reg[31:8] == $past(stack_reg[31:8]) &&
      stack_reg[7:0] == $past(gr_wr_data[7:0])) else $error("byte write disturbed other bits");

   zero_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
      (flag_en && flag_kind == crf_pkg::FK_LOGIC && !ctl_op_en) |=>
      flag_z == ($past(flag_a & size_mask(flag_size)) == 32'h00000000))
      else $error("zero flag wrong");

   half_carry_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
      (flag_en && flag_kind == crf_pkg::FK_ADD && flag_size == crf_pkg::SZ_BYTE &&
       !flag_use_x && flag_a[3:0] == 4'hF && flag_b[3:0] == 4'h1 && !ctl_op_en)
      |=> condition_code[crf_pkg::CC_H]) else $error("half carry missed");

   flags_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!flag_en && !ctl_op_en) |=> $stable(condition_code[3:0]))
      else $error("flags changed without an update");

   hold_off_seen_c: cover property (@(posedge ref_clk) disable iff (rst)
      irq_block ##1 irq_block ##1 irq_block ##1 !irq_block);
   exception_seen_c: cover property (@(posedge ref_clk) disable iff (rst)
      exc_start ##1 irq_mask_i);
   long_carry_c: cover property (@(posedge ref_clk) disable iff (rst)
      flag_en && flag_kind == crf_pkg::FK_ADD && flag_size == crf_pkg::SZ_LONG ##1 flag_c);
   store_seen_c: cover property (@(posedge ref_clk) disable iff (rst)
      ctl_op_en && ctl_op == crf_pkg::CO_STORE ##1 !irq_block);

endmodule

// ==== crf_exec_model.sv ====
// Purpose: stand-in for the exception logic beside the cpu register file
// Assumes: one clock, outputs change just after the rising edge
// Notes: only the exception start and vector load are modelled
`timescale 1ns/1ps
module crf_exec_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic exc_go,
   input wire logic [23:0] exc_vec,
   output logic exc_start,
   output logic pc_load_en,
   output logic [23:0] pc_load_val
);
   // one-cycle exception entry: raise the start pulse and load the vector together
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         exc_start <= 1'h0;
         pc_load_en <= 1'h0;
         pc_load_val <= 24'h000000;
      end else begin
         exc_start <= exc_go;
         pc_load_en <= exc_go;
         // an idle load bus inverts every bit each cycle, so it repeats the last vector every other cycle
         pc_load_val <= exc_go ? exc_vec : ~pc_load_val;
      end
   end
endmodule

// ==== crf_pkg.sv ====
// Purpose: shared constants and types for the cpu register file and flags
// Assumes: one clock domain, ref_clk at 250 MHz
// Notes: field positions, reset values and encodings live here only
package crf_pkg;

   // operand width codes shared by the register ports and the flag port
   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_LONG = 2'h2
   } crf_size_e;

   // control-register instructions
   typedef enum logic [2:0] {
      CO_LOAD  = 3'h0,
      CO_STORE = 3'h1,
      CO_AND   = 3'h2,
      CO_OR    = 3'h3,
      CO_XOR   = 3'h4
   } crf_ctl_op_e;

   // classes of flag update
   typedef enum logic [2:0] {
      FK_ADD   = 3'h0,
      FK_SUB   = 3'h1,
      FK_NEG   = 3'h2,
      FK_LOGIC = 3'h3,
      FK_SHIFT = 3'h4,
      FK_BIT   = 3'h5
   } crf_flag_e;

   // condition-code bit positions
   localparam int CC_I = 7;
   localparam int CC_SPARE6 = 6;
   localparam int CC_H = 5;
   localparam int CC_USER = 4;
   localparam int CC_N = 3;
   localparam int CC_Z = 2;
   localparam int CC_V = 1;
   localparam int CC_C = 0;

   // extended control layout
   localparam int XC_TRACE = 7;
   localparam logic [3:0] XC_RSVD = 4'hF;

   // reset values; flags other than the mask have no defined value, zero is used
   localparam logic [7:0] CC_RST = 8'h80;
   localparam logic [2:0] MASK_RST = 3'h7;
   localparam logic TRACE_RST = 1'b0;
   localparam logic [23:0] PC_RST = 24'h000000;

   // program counter step per instruction word
   localparam logic [23:0] PC_STEP = 24'h000002;

   // states during which interrupts are held off after an extended control write
   localparam logic [1:0] BLK_STATES = 2'h3;

   // index of the stack register among the general registers
   localparam logic [2:0] SP_IDX = 3'h7;

   typedef struct packed {
      logic [7:0][31:0] gr;
      logic [23:0] pc;
      logic trace;
      logic [2:0] mask;
      logic [7:0] cond;
      logic [1:0] blk;
      logic [31:0] rd;
      logic rd_bit;
      logic [7:0] store_control_op;
      logic [31:0] alu;
   } crf_state_s;

   localparam crf_state_s STATE_RST = '{
      gr: '0, pc: PC_RST, trace: TRACE_RST, mask: MASK_RST,
      cond: CC_RST, blk: 2'h0, rd: 32'h00000000, rd_bit: 1'b0, store_control_op: 8'h00,
      alu: 32'h00000000
   };

endpackage

// ==== tb.sv ====
// Purpose: self-checking bench for the cpu register file and flags
// Assumes: inputs change at the falling edge, results settle before the next one
// Notes: exception entry comes from the partner model
`timescale 1ns/1ps
module tb;
   logic ref_clk, rst, gr_wr_en, gr_wr_sel, gr_rd_sel, pc_inc_en, ctl_op_en, ctl_to_ext;
   logic flag_en, flag_use_x, flag_shift_out, flag_bit_val, exc_go, exc_start, pc_load_en;
   logic [2:0] gr_wr_idx, gr_rd_idx, bit_sel, ctl_op, flag_kind, mask_level;
   logic [1:0] gr_wr_size, gr_rd_size, flag_size;
   logic [31:0] gr_wr_data, gr_rd_data, stack_reg, flag_a, flag_b, alu_result;
   logic [23:0] pc_load_val, program_counter, fetch_addr, exc_vec;
   logic [7:0] ctl_operand, ctl_store_data, extended_control, condition_code;
   logic [3:0] bcd_upper, bcd_lower;
   logic rd_bit, trace_en, irq_mask_i, irq_block, flag_n, flag_z, flag_v, flag_c;
   int n_errors = 0;
   int check_count = 0;
   logic [2:0] eop [4];
   logic [7:0] eopd [4], eexp [4], cexp [4], copd [4];

   crf_core dut (.ref_clk(ref_clk), .rst(rst), .gr_wr_en(gr_wr_en), .gr_wr_idx(gr_wr_idx),
      .gr_wr_size(gr_wr_size), .gr_wr_sel(gr_wr_sel), .gr_wr_data(gr_wr_data),
      .gr_rd_idx(gr_rd_idx), .gr_rd_size(gr_rd_size), .gr_rd_sel(gr_rd_sel), .bit_sel(bit_sel),
      .gr_rd_data(gr_rd_data), .rd_bit(rd_bit), .bcd_upper(bcd_upper), .bcd_lower(bcd_lower),
      .stack_reg(stack_reg), .pc_load_en(pc_load_en), .pc_load_val(pc_load_val),
      .pc_inc_en(pc_inc_en), .program_counter(program_counter), .fetch_addr(fetch_addr),
      .ctl_op_en(ctl_op_en), .ctl_op(ctl_op), .ctl_to_ext(ctl_to_ext),
      .ctl_operand(ctl_operand), .ctl_store_data(ctl_store_data), .exc_start(exc_start),
      .flag_en(flag_en), .flag_kind(flag_kind), .flag_size(flag_size),
      .flag_use_x(flag_use_x), .flag_a(flag_a), .flag_b(flag_b),
      .flag_shift_out(flag_shift_out), .flag_bit_val(flag_bit_val), .alu_result(alu_result),
      .extended_control(extended_control), .condition_code(condition_code),
      .trace_en(trace_en), .mask_level(mask_level), .irq_mask_i(irq_mask_i),
      .irq_block(irq_block), .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v),
      .flag_c(flag_c));

   crf_exec_model exec (.ref_clk(ref_clk), .rst(rst), .exc_go(exc_go), .exc_vec(exc_vec),
      .exc_start(exc_start), .pc_load_en(pc_load_en), .pc_load_val(pc_load_val));

   // 250 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // all tasks start and end at a falling edge
   task automatic wr(input logic [2:0] i, input logic [1:0] s, input logic sl,
                     input logic [31:0] d);
      gr_wr_en = 1'h1;
      gr_wr_idx = i;
      gr_wr_size = s;
      gr_wr_sel = sl;
      gr_wr_data = d;
      // enable stays up so back-to-back writes need no gap; the caller lowers it
      @(negedge ref_clk);
   endtask

   task automatic rd(input logic [2:0] i, input logic [1:0] s, input logic sl,
                     input logic [2:0] b, input logic [31:0] e, input logic eb);
      gr_rd_idx = i;
      gr_rd_size = s;
      gr_rd_sel = sl;
      bit_sel = b;
      @(negedge ref_clk);
      chk(gr_rd_data, e, "read data");
      if (s == crf_pkg::SZ_BYTE) begin
         chk(rd_bit, eb, "selected bit");
      end
   endtask

   task automatic ctl(input logic [2:0] op, input logic ext, input logic [7:0] opd);
      ctl_op_en = 1'h1;
      ctl_op = op;
      ctl_to_ext = ext;
      ctl_operand = opd;
      @(negedge ref_clk);
      ctl_op_en = 1'h0;
   endtask

   task automatic flg(input logic [2:0] k, input logic [1:0] s, input logic x,
                      input logic [31:0] a, input logic [31:0] b, input logic so,
                      input logic bv, input logic [31:0] res, input logic h,
                      input logic [3:0] nzvc);
      logic [7:0] cc;
      cc = condition_code;
      flag_en = 1'h1;
      flag_kind = k;
      flag_size = s;
      flag_use_x = x;
      flag_a = a;
      flag_b = b;
      flag_shift_out = so;
      flag_bit_val = bv;
      @(negedge ref_clk);
      chk(condition_code, {cc[7:6], h, cc[4], nzvc}, "flags");
      chk({flag_n, flag_z, flag_v, flag_c}, nzvc, "branch flags");
      if (k != crf_pkg::FK_BIT) begin
         chk(alu_result, res, "result");
      end
   endtask

   // watchdog: the tests need under a hundred cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      summarize();
   end

   initial begin
      {gr_wr_en, gr_wr_sel, gr_rd_sel, pc_inc_en, ctl_op_en} = '0;
      {flag_en, flag_use_x, flag_shift_out, flag_bit_val, exc_go, ctl_to_ext} = '0;
      {gr_wr_idx, gr_rd_idx, bit_sel, ctl_op, flag_kind} = '0;
      {gr_wr_size, gr_rd_size, flag_size, gr_wr_data, flag_a, flag_b} = '0;
      exc_vec = 24'h001235;
      ctl_operand = 8'h00;
      eop = '{crf_pkg::CO_LOAD, crf_pkg::CO_OR, crf_pkg::CO_AND, crf_pkg::CO_XOR};
      eopd = '{8'h00, 8'h83, 8'h7E, 8'h05};
      eexp = '{8'h78, 8'hFB, 8'h7A, 8'h7F};
      cexp = '{8'h50, 8'h5F, 8'h1F, 8'h5E};
      copd = '{8'h50, 8'h0F, 8'h3F, 8'h41};
      rst = 1'h1;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'h0;
      chk(extended_control, 8'h7F, "reset ext");
      chk(condition_code[7], 1'h1, "reset mask");
      chk(irq_block, 1'h0, "reset block");
      // sub-register writes back to back, then views of the same register
      wr(3'h2, crf_pkg::SZ_LONG, 1'h0, 32'h12345678);
      wr(3'h2, crf_pkg::SZ_WORD, 1'h1, 32'h0000ABCD);
      wr(3'h2, crf_pkg::SZ_BYTE, 1'h1, 32'h000000EE);
      wr(3'h2, crf_pkg::SZ_BYTE, 1'h0, 32'h00000059);
      gr_wr_en = 1'h0;
      rd(3'h2, crf_pkg::SZ_LONG, 1'h0, 3'h0, 32'hABCDEE59, 1'h0);
      rd(3'h2, crf_pkg::SZ_WORD, 1'h1, 3'h0, 32'h0000ABCD, 1'h0);
      rd(3'h2, crf_pkg::SZ_WORD, 1'h0, 3'h0, 32'h0000EE59, 1'h0);
      rd(3'h2, crf_pkg::SZ_BYTE, 1'h1, 3'h4, 32'h000000EE, 1'h0);
      rd(3'h2, crf_pkg::SZ_BYTE, 1'h0, 3'h3, 32'h00000059, 1'h1);
      chk({bcd_upper, bcd_lower}, 8'h59, "bcd digits");
      wr(3'h7, crf_pkg::SZ_LONG, 1'h0, 32'hCAFE1234);
      wr(3'h7, crf_pkg::SZ_WORD, 1'h0, 32'h00005678);
      chk(stack_reg, 32'hCAFE5678, "stack reg");
      wr(3'h7, crf_pkg::SZ_BYTE, 1'h0, 32'h0000009A);
      gr_wr_en = 1'h0;
      chk(stack_reg, 32'hCAFE569A, "stack byte");
      // extended control: each op, then the three-cycle hold-off
      for (int i = 0; i < 4; i++) begin
         ctl(eop[i], 1'h1, eopd[i]);
         chk(extended_control, eexp[i], "ext ctl");
         chk(trace_en, eexp[i][7], "trace");
         chk(mask_level, eexp[i][2:0], "mask level");
         for (int j = 0; j < 4; j++) begin
            chk(irq_block, j < 3, "hold-off");
            @(negedge ref_clk);
         end
      end
      ctl(crf_pkg::CO_STORE, 1'h1, 8'h00);
      chk(ctl_store_data, 8'h7F, "ext store");
      chk(irq_block, 1'h0, "store hold-off");
      @(negedge ref_clk);
      // condition code through the control ops; bit 6 must not mask
      for (int i = 0; i < 4; i++) begin
         ctl(eop[i], 1'h0, copd[i]);
         chk(condition_code, cexp[i], "cond code");
         chk(irq_mask_i, cexp[i][7], "irq mask");
         @(negedge ref_clk);
      end
      ctl(crf_pkg::CO_STORE, 1'h0, 8'h00);
      chk(ctl_store_data, 8'h5E, "cc store");
      // exception entry sets the mask and loads the vector
      exc_go = 1'h1;
      @(negedge ref_clk);
      exc_go = 1'h0;
      @(negedge ref_clk);
      chk(condition_code, 8'hDE, "exc mask");
      chk(program_counter, 24'h001235, "pc load");
      chk(fetch_addr, 24'h001234, "fetch addr");
      pc_inc_en = 1'h1;
      @(negedge ref_clk);
      pc_inc_en = 1'h0;
      chk(fetch_addr, 24'h001236, "pc step");
      // flag updates across kinds and widths
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_BYTE, 0, 32'h0F, 32'h01, 0, 0, 32'h10, 1, 4'h0);
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_BYTE, 0, 32'h7F, 32'h01, 0, 0, 32'h80, 1, 4'hA);
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_BYTE, 0, 32'hFF, 32'h01, 0, 0, 32'h00, 1, 4'h5);
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_WORD, 0, 32'h0FFF, 32'h01, 0, 0, 32'h1000, 1, 4'h0);
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_LONG, 0, 32'h0FFFFFFF, 32'h01, 0, 0, 32'h10000000, 1,
          4'h0);
      flg(crf_pkg::FK_SUB, crf_pkg::SZ_BYTE, 0, 32'h10, 32'h01, 0, 0, 32'h0F, 1, 4'h0);
      flg(crf_pkg::FK_SUB, crf_pkg::SZ_BYTE, 0, 32'h00, 32'h01, 0, 0, 32'hFF, 1, 4'h9);
      flg(crf_pkg::FK_SUB, crf_pkg::SZ_BYTE, 0, 32'h80, 32'h01, 0, 0, 32'h7F, 1, 4'h2);
      flg(crf_pkg::FK_NEG, crf_pkg::SZ_BYTE, 0, 32'h01, 32'h00, 0, 0, 32'hFF, 1, 4'h9);
      flg(crf_pkg::FK_ADD, crf_pkg::SZ_BYTE, 1, 32'h01, 32'h01, 0, 0, 32'h03, 0, 4'h0);
      flg(crf_pkg::FK_LOGIC, crf_pkg::SZ_LONG, 0, 32'h00, 32'h00, 0, 0, 32'h00, 0, 4'h4);
      flg(crf_pkg::FK_SHIFT, crf_pkg::SZ_BYTE, 0, 32'h80, 32'h00, 1, 0, 32'h80, 0, 4'h9);
      flg(crf_pkg::FK_BIT, crf_pkg::SZ_BYTE, 0, 32'h00, 32'h00, 0, 0, 32'h00, 0, 4'h8);
      {flag_en, flag_use_x} = '0;
      @(negedge ref_clk);
      chk(condition_code, 8'hD8, "idle flags");
      summarize();
   end
endmodule
